// ==== common/cstw_pkg.sv ====
package cstw_pkg;

  // Width of one timer byte and of the free-running prescaler.
  localparam int unsigned CSTW_W     = 8;
  localparam int unsigned CSTW_PRE_W = 7;
  localparam int unsigned CSTW_EXT_W = 3;

  typedef logic [2:0] cstw_sel_t;

  // Clock select codes of the upper timer.
  localparam cstw_sel_t UP_SEL_MAIN   = 3'h0;
  localparam cstw_sel_t UP_SEL_DIV8   = 3'h1;
  localparam cstw_sel_t UP_SEL_DIV128 = 3'h2;
  localparam cstw_sel_t UP_SEL_SUB    = 3'h3;
  localparam cstw_sel_t UP_SEL_LMATCH = 3'h4;
  localparam cstw_sel_t UP_SEL_LWAVE  = 3'h5;

  // Clock select codes of the lower and third timers.
  localparam cstw_sel_t EX_SEL_MAIN = 3'h0;
  localparam cstw_sel_t EX_SEL_DIV  = 3'h1;
  localparam cstw_sel_t EX_SEL_EXT  = 3'h2;
  localparam cstw_sel_t EX_SEL_EXT2 = 3'h3;
  localparam cstw_sel_t EX_SEL_EXT4 = 3'h4;
  localparam cstw_sel_t EX_SEL_EXT8 = 3'h5;

  // Prescaler masks: a tick fires when all masked bits are one.
  localparam logic [CSTW_PRE_W-1:0] PRE_DIV4   = 7'h03;
  localparam logic [CSTW_PRE_W-1:0] PRE_DIV8   = 7'h07;
  localparam logic [CSTW_PRE_W-1:0] PRE_DIV16  = 7'h0f;
  localparam logic [CSTW_PRE_W-1:0] PRE_DIV128 = 7'h7f;

  // External edge divider masks.
  localparam logic [CSTW_EXT_W-1:0] EXT_DIV2 = 3'h1;
  localparam logic [CSTW_EXT_W-1:0] EXT_DIV4 = 3'h3;
  localparam logic [CSTW_EXT_W-1:0] EXT_DIV8 = 3'h7;

  // Counter values.
  localparam logic [CSTW_W-1:0] COUNT_ZERO = 8'h00;
  localparam logic [CSTW_W-1:0] COUNT_TOP  = 8'hff;

endpackage : cstw_pkg

// ==== src/cstw_chan.sv ====
`timescale 1ns/10ps
`default_nettype none

// One 8-bit counter byte with its square-wave level and match pulse.
module cstw_chan
  import cstw_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              run,
  input  wire logic              out_en,
  input  wire logic              step,
  input  wire logic              wrap,
  input  wire logic              fire,
  output logic [CSTW_W-1:0]      count,
  output logic                   wave,
  output logic                   irq
);

  logic [CSTW_W-1:0] cnt_reg;
  logic [CSTW_W-1:0] cnt_next;
  logic              wave_reg;
  logic              wave_next;
  logic              irq_reg;
  logic              irq_next;

  // Next count, wave level and match pulse.
  always_comb begin
    cnt_next  = cnt_reg;
    wave_next = wave_reg;
    if (!run) begin
      cnt_next = COUNT_ZERO;
    end else if (step) begin
      cnt_next = wrap ? COUNT_ZERO : cnt_reg + 8'h01;
    end
    // stop forces low: a stopped or disabled output rests low.
    // start low: the level starts low when the output is enabled.
    if (!run || !out_en) begin
      wave_next = 1'b0;
    end else if (step && fire) begin
      wave_next = ~wave_reg;
    end
    // one pulse: one cycle per clearing match.
    irq_next = run && step && fire;
  end

  // Registers of the byte.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg  <= COUNT_ZERO;
      wave_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      wave_reg <= wave_next;
      irq_reg  <= irq_next;
    end
  end

  assign count = cnt_reg;
  assign wave  = wave_reg;
  assign irq   = irq_reg;

endmodule : cstw_chan

`default_nettype wire

// ==== src/cstw_timer.sv ====
// Behaviour
// - Standalone square-wave mode toggles the timer's pin on each compare match.
// - Standalone match clears the counter, keeps counting, raises the match pulse.
// - Clearing a timer's count enable forces its square-wave output low.
// - Enabling the output starts the square wave at a low level.
// - Upper select: main, main/8, main/128, subsystem, lower match, lower wave.
// - Lower select: main, main/4, external edges, external/2, /4, /8.
// - Third select: main, main/16, its external edges, external/2, /4, /8.
// - Cascade uses upper counter as high byte, lower counter as low byte.
// - Cascade starts and clears only by the lower count enable.
// - Cascade full match clears both bytes and raises only the lower pulse.
// - Low-byte match alone neither clears nor raises a pulse.
// - Cascade runs on the lower clock, low byte carrying into high byte.
// - Cascade event counting advances on each lower external input edge.
// - Cascade toggles lower pin on full match, forced low when stopped.
// - Interval and event modes clear on match and raise the match pulse.
`timescale 1ns/10ps
`default_nettype none

module cstw_timer
  import cstw_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              cascade_mode,
  input  wire logic              upper_count_enable,
  input  wire logic              lower_count_enable,
  input  wire logic              third_count_enable,
  input  wire logic              upper_output_enable,
  input  wire logic              lower_output_enable,
  input  wire logic              third_output_enable,
  input  wire logic [2:0]        upper_clock_select,
  input  wire logic [2:0]        lower_clock_select,
  input  wire logic [2:0]        third_clock_select,
  input  wire logic [CSTW_W-1:0] upper_compare,
  input  wire logic [CSTW_W-1:0] lower_compare,
  input  wire logic [CSTW_W-1:0] third_compare,
  input  wire logic              sub_clock_pin,
  input  wire logic              ext_clock_input,
  input  wire logic              third_ext_clock_input,
  output logic [CSTW_W-1:0]      upper_counter,
  output logic [CSTW_W-1:0]      lower_counter,
  output logic [CSTW_W-1:0]      third_counter,
  output logic                   upper_match_irq,
  output logic                   lower_match_irq,
  output logic                   third_match_irq,
  output logic                   upper_wave_pin,
  output logic                   upper_wave_oe,
  output logic                   lower_wave_pin,
  output logic                   lower_wave_oe,
  output logic                   third_wave_pin,
  output logic                   third_wave_oe
);

  logic [CSTW_PRE_W-1:0] pre_reg;
  logic [CSTW_PRE_W-1:0] pre_next;
  logic [2:0]            pin_raw;
  logic [2:0]            edge_hit;
  logic [2:0]            ediv1;
  logic [2:0]            ediv2;
  logic [2:0]            ediv3;
  logic [2:0]            tick;
  logic [2:0]            match;
  logic [2:0]            run;
  logic [2:0]            oen;
  logic [2:0]            step;
  logic [2:0]            wrap;
  logic [2:0]            fire;
  logic [2:0]            wave;
  logic [2:0]            irq;
  logic [CSTW_W-1:0]     cnt    [3];
  logic [CSTW_W-1:0]     cmp    [3];
  logic                  both_m;

  assign pin_raw = {third_ext_clock_input, ext_clock_input, sub_clock_pin};
  assign cmp[0]  = upper_compare;
  assign cmp[1]  = lower_compare;
  assign cmp[2]  = third_compare;

  // Free-running prescaler of the main clock.
  always_comb begin
    pre_next = pre_reg + 7'h01;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // Pin synchronisers, rising-edge detect and edge dividers, one per pin.
  for (genvar p = 0; p < 3; p++) begin : g_pin
    logic                  s1_reg;
    logic                  s2_reg;
    logic                  s3_reg;
    logic [CSTW_EXT_W-1:0] ecnt_reg;
    logic [CSTW_EXT_W-1:0] ecnt_next;

    always_comb begin
      edge_hit[p] = s2_reg && !s3_reg;
      ecnt_next   = edge_hit[p] ? ecnt_reg + 3'h1 : ecnt_reg;
      ediv1[p]    = edge_hit[p] && ((ecnt_reg & EXT_DIV2) == EXT_DIV2);
      ediv2[p]    = edge_hit[p] && ((ecnt_reg & EXT_DIV4) == EXT_DIV4);
      ediv3[p]    = edge_hit[p] && ((ecnt_reg & EXT_DIV8) == EXT_DIV8);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        s1_reg   <= 1'b0;
        s2_reg   <= 1'b0;
        s3_reg   <= 1'b0;
        ecnt_reg <= '0;
      end else begin
        s1_reg   <= pin_raw[p];
        s2_reg   <= s1_reg;
        s3_reg   <= s2_reg;
        ecnt_reg <= ecnt_next;
      end
    end
  end

  // Count clock selection per timer; codes 6 and 7 give no tick.
  always_comb begin
    tick = '0;
    unique case (upper_clock_select)
      UP_SEL_MAIN:   tick[0] = 1'b1;
      UP_SEL_DIV8:   tick[0] = (pre_reg & PRE_DIV8) == PRE_DIV8;
      UP_SEL_DIV128: tick[0] = (pre_reg & PRE_DIV128) == PRE_DIV128;
      UP_SEL_SUB:    tick[0] = edge_hit[0];
      UP_SEL_LMATCH: tick[0] = irq[1];
      UP_SEL_LWAVE:  tick[0] = irq[1] && wave[1];
      default:       tick[0] = 1'b0;
    endcase
    unique case (lower_clock_select)
      EX_SEL_MAIN: tick[1] = 1'b1;
      EX_SEL_DIV:  tick[1] = (pre_reg & PRE_DIV4) == PRE_DIV4;
      EX_SEL_EXT:  tick[1] = edge_hit[1];
      EX_SEL_EXT2: tick[1] = ediv1[1];
      EX_SEL_EXT4: tick[1] = ediv2[1];
      EX_SEL_EXT8: tick[1] = ediv3[1];
      default:     tick[1] = 1'b0;
    endcase
    unique case (third_clock_select)
      EX_SEL_MAIN: tick[2] = 1'b1;
      EX_SEL_DIV:  tick[2] = (pre_reg & PRE_DIV16) == PRE_DIV16;
      EX_SEL_EXT:  tick[2] = edge_hit[2];
      EX_SEL_EXT2: tick[2] = ediv1[2];
      EX_SEL_EXT4: tick[2] = ediv2[2];
      EX_SEL_EXT8: tick[2] = ediv3[2];
      default:     tick[2] = 1'b0;
    endcase
  end

  // Step, clear and toggle decisions for stand-alone and cascaded use.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      match[i] = cnt[i] == cmp[i];
    end
    both_m = match[0] && match[1];
    run    = {third_count_enable, lower_count_enable, upper_count_enable};
    oen    = {third_output_enable, lower_output_enable, upper_output_enable};
    // own match: stand-alone toggle and pulse on match.
    // clear on match: counter wraps to zero.
    // interval modes: same clear for interval and events.
    step   = tick;
    wrap   = match;
    fire   = match;
    if (cascade_mode) begin
      // lower enable only: upper byte follows lower enable.
      run[0]  = lower_count_enable;
      oen[0]  = 1'b0;
      // carry chain: upper steps on lower overflow.
      // event counting: lower external edges drive both bytes.
      step[0] = tick[1] && (both_m || cnt[1] == COUNT_TOP);
      // joint match: both clear, only lower pulse.
      // low only: a low-byte match alone is ignored.
      wrap[0] = both_m;
      fire[0] = 1'b0;
      wrap[1] = both_m;
      // cascade wave: lower pin toggles on full match.
      fire[1] = both_m;
    end
  end

  // byte order: upper byte high, lower byte low.
  for (genvar c = 0; c < 3; c++) begin : g_chan
    cstw_chan u_chan (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .run     (run[c]),
      .out_en  (oen[c]),
      .step    (step[c]),
      .wrap    (wrap[c]),
      .fire    (fire[c]),
      .count   (cnt[c]),
      .wave    (wave[c]),
      .irq     (irq[c])
    );
  end

  // Output pins follow the wave levels; enables follow the output enables, except the upper one, which is forced off in cascade.
  assign upper_counter   = cnt[0];
  assign lower_counter   = cnt[1];
  assign third_counter   = cnt[2];
  assign upper_match_irq = irq[0];
  assign lower_match_irq = irq[1];
  assign third_match_irq = irq[2];
  assign upper_wave_pin  = wave[0];
  assign lower_wave_pin  = wave[1];
  assign third_wave_pin  = wave[2];
  assign upper_wave_oe   = oen[0];
  assign lower_wave_oe   = lower_output_enable;
  assign third_wave_oe   = third_output_enable;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence cas_hit;
    cascade_mode && lower_count_enable && tick[1] && both_m;
  endsequence

  sequence both_cleared;
    lower_counter == COUNT_ZERO && upper_counter == COUNT_ZERO ##0 lower_match_irq;
  endsequence

  lower_wave_toggle_a: assert property (
    !cascade_mode && lower_count_enable && lower_output_enable && tick[1] && match[1]
    |=> lower_wave_pin != $past(lower_wave_pin))
    else $error("lower wave did not toggle on match");

  third_match_clear_a: assert property (
    !cascade_mode && third_count_enable && tick[2] && match[2]
    |=> third_counter == COUNT_ZERO && third_match_irq)
    else $error("third counter not cleared with pulse");

  stop_forces_low_a: assert property (
    !third_count_enable |=> !third_wave_pin)
    else $error("third wave not low while stopped");

  disabled_wave_low_a: assert property (
    !lower_output_enable |=> !lower_wave_pin)
    else $error("lower wave not low while disabled");

  upper_div8_tick_a: assert property (
    upper_clock_select == UP_SEL_DIV8 && tick[0] |-> pre_reg[2:0] == 3'h7)
    else $error("upper divide by eight mistimed");

  lower_ext_edge_a: assert property (
    lower_clock_select == EX_SEL_EXT |-> tick[1] == edge_hit[1])
    else $error("lower external edge not used");

  cascade_clear_a: assert property (
    cas_hit |=> both_cleared ##0 !upper_match_irq)
    else $error("cascade match did not clear both bytes");

  low_only_quiet_a: assert property (
    cascade_mode && lower_count_enable && tick[1] && match[1] && !match[0]
    |=> !lower_match_irq)
    else $error("low byte match alone raised a pulse");

  cascade_stop_a: assert property (
    cascade_mode && !lower_count_enable |=> upper_counter == COUNT_ZERO)
    else $error("upper byte ran while lower stopped");

  carry_step_a: assert property (
    cascade_mode && lower_count_enable && tick[1] && cnt[1] == COUNT_TOP && !both_m
    |=> upper_counter == $past(upper_counter) + 8'h01)
    else $error("no carry into upper byte");

  bad_select_a: assert property (
    third_clock_select[2:1] == 2'b11 |-> !tick[2])
    else $error("prohibited select advanced the counter");

endmodule : cstw_timer

`default_nettype wire

// ==== tb/cstw_testbench.sv ====
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin n_errors++; $display("CHECK FAILED at %0t: %s", $time, msg); end end

module testbench;
  import cstw_pkg::*;

  logic              sys_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              cascade_mode = 1'b0;
  logic              upper_count_enable = 1'b0;
  logic              lower_count_enable = 1'b0;
  logic              third_count_enable = 1'b0;
  logic              upper_output_enable = 1'b0;
  logic              lower_output_enable = 1'b0;
  logic              third_output_enable = 1'b0;
  cstw_sel_t         upper_clock_select = 3'h0;
  cstw_sel_t         lower_clock_select = 3'h0;
  cstw_sel_t         third_clock_select = 3'h0;
  logic [CSTW_W-1:0] upper_compare = 8'h00;
  logic [CSTW_W-1:0] lower_compare = 8'h00;
  logic [CSTW_W-1:0] third_compare = 8'h00;
  logic              sub_clock_pin = 1'b0;
  logic              ext_clock_input = 1'b0;
  logic              third_ext_clock_input = 1'b0;
  logic [CSTW_W-1:0] upper_counter, lower_counter, third_counter;
  logic              upper_match_irq, lower_match_irq, third_match_irq;
  logic              upper_wave_pin, lower_wave_pin, third_wave_pin;
  logic              upper_wave_oe, lower_wave_oe, third_wave_oe;
  logic [1:0]        phase = 2'h0;
  int                n_errors = 0;
  int                checked = 0;
  int                up_pulses = 0;
  int                p;
  int                tw[14] = '{2, 2, 2, 2, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0};
  int                ts[14] = '{0, 1, 2, 3, 1, 2, 3, 4, 5, 1, 2, 3, 4, 5};
  int                tp[14] = '{4, 16, 256, 16, 8, 16, 32, 64, 128, 32, 16, 32, 64, 128};

  cstw_timer DUT (
    .sys_clk(sys_clk), .nrst(nrst), .cascade_mode(cascade_mode),
    .upper_count_enable(upper_count_enable), .lower_count_enable(lower_count_enable),
    .third_count_enable(third_count_enable), .upper_output_enable(upper_output_enable),
    .lower_output_enable(lower_output_enable), .third_output_enable(third_output_enable),
    .upper_clock_select(upper_clock_select), .lower_clock_select(lower_clock_select),
    .third_clock_select(third_clock_select), .upper_compare(upper_compare),
    .lower_compare(lower_compare), .third_compare(third_compare),
    .sub_clock_pin(sub_clock_pin), .ext_clock_input(ext_clock_input),
    .third_ext_clock_input(third_ext_clock_input), .upper_counter(upper_counter),
    .lower_counter(lower_counter), .third_counter(third_counter),
    .upper_match_irq(upper_match_irq), .lower_match_irq(lower_match_irq),
    .third_match_irq(third_match_irq), .upper_wave_pin(upper_wave_pin),
    .upper_wave_oe(upper_wave_oe), .lower_wave_pin(lower_wave_pin),
    .lower_wave_oe(lower_wave_oe), .third_wave_pin(third_wave_pin),
    .third_wave_oe(third_wave_oe)
  );

  // Clock of 8 ns period.
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // External and subsystem pins rise once every 8 cycles.
  always @(posedge sys_clk) begin
    phase <= phase + 2'h1;
    if (phase == 2'h3) begin
      ext_clock_input       <= ~ext_clock_input;
      third_ext_clock_input <= ~third_ext_clock_input;
      sub_clock_pin         <= ~sub_clock_pin;
    end
  end

  // Counts upper match pulses so that cascade can prove it stays quiet.
  always @(posedge sys_clk) begin
    if (upper_match_irq === 1'b1) up_pulses++;
  end

  function automatic logic irq_of(input int w);
    return (w == 2) ? upper_match_irq : (w == 1) ? lower_match_irq : third_match_irq;
  endfunction : irq_of

  // Stops all timers before selects change, then starts the chosen ones.
  // stop first
  task automatic cfg(input logic casc, input cstw_sel_t us, input cstw_sel_t ls,
                     input cstw_sel_t tsl, input logic [7:0] uc, input logic [7:0] lc,
                     input logic [7:0] tc, input logic [2:0] en, input logic [2:0] oe);
    @(posedge sys_clk);
    {upper_count_enable, lower_count_enable, third_count_enable} <= 3'b000;
    repeat (2) @(posedge sys_clk);
    cascade_mode <= casc;
    {upper_clock_select, lower_clock_select, third_clock_select} <= {us, ls, tsl};
    {upper_output_enable, lower_output_enable, third_output_enable} <= oe;
    {upper_compare, lower_compare, third_compare} <= {uc, lc, tc};
    @(posedge sys_clk);
    {upper_count_enable, lower_count_enable, third_count_enable} <= en;
  endtask : cfg

  // Returns the number of cycles between two match pulses of one timer.
  task automatic measure(input int w, output int per);
    int n;
    n = 0;
    per = 0;
    @(posedge sys_clk);
    #1;
    while (irq_of(w) !== 1'b1 && n < 6000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    while (irq_of(w) !== 1'b1 && per < 6000) begin
      @(posedge sys_clk);
      #1;
      per++;
    end
    per++;
  endtask : measure

  task automatic final_report();
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // Watchdog against a hung wait.
  initial begin
    #400000;
    n_errors++;
    final_report();
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // Square wave on the lower timer with compare 02.
    cfg(1'b0, 3'h0, EX_SEL_MAIN, 3'h0, 8'h00, 8'h02, 8'h00, 3'b010, 3'b010);
    @(posedge sys_clk);
    #1;
    `CHK(lower_wave_pin, 1'b0, "wave not low at start")
    `CHK({upper_wave_oe, lower_wave_oe, third_wave_oe, upper_wave_pin, third_wave_pin}, 5'b01000, "output enables wrong")
    measure(1, p);
    `CHK(lower_counter, 8'h00, "counter not cleared on match")
    `CHK(lower_wave_pin, 1'b0, "wave not toggled twice")
    @(posedge sys_clk);
    #1;
    `CHK({lower_match_irq, lower_counter}, 9'h001, "pulse too long")
    `CHK(p, 3, "period wrong for compare 02")
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(lower_wave_pin, 1'b1, "wave not toggled on match")
    @(posedge sys_clk);
    lower_count_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK({lower_wave_pin, lower_counter}, 9'h000, "stop did not clear wave")
    // Clock select codes 0 to 3 of the upper timer, 1 to 5 of the lower and third timers.
    for (int i = 0; i < 14; i++) begin
      cfg(1'b0, cstw_sel_t'(ts[i]), cstw_sel_t'(ts[i]), cstw_sel_t'(ts[i]),
          8'h01 + 8'(i == 0) * 8'h02, 8'h01, 8'h01, 3'(1 << tw[i]), 3'b000);
      measure(tw[i], p);
      `CHK(p, tp[i], "period wrong for a select code")
    end
    // Upper timer counting lower match pulses, then lower wave rises.
    cfg(1'b0, UP_SEL_LMATCH, EX_SEL_MAIN, 3'h0, 8'h02, 8'h01, 8'h01, 3'b110, 3'b000);
    measure(2, p);
    `CHK(p, 6, "lower match clock wrong")
    cfg(1'b0, UP_SEL_LWAVE, EX_SEL_MAIN, 3'h0, 8'h02, 8'h01, 8'h01, 3'b110, 3'b010);
    measure(2, p);
    `CHK(p, 12, "lower wave clock wrong")
    // Prohibited codes never advance.
    for (int c = 6; c < 8; c++) begin
      cfg(1'b0, 3'(c), 3'(c), 3'(c), 8'h05, 8'h05, 8'h05, 3'b111, 3'b000);
      repeat (40) @(posedge sys_clk);
      #1;
      `CHK({upper_counter, lower_counter, third_counter}, 24'h0, "advanced on code 6 or 7")
    end
    // Cascade interval timer, upper enable left low and upper output off.
    // upper output off
    cfg(1'b1, 3'h0, EX_SEL_MAIN, 3'h0, 8'h01, 8'h02, 8'h00, 3'b010, 3'b010);
    up_pulses = 0;
    measure(1, p);
    `CHK(p, 259, "cascade period wrong")
    repeat (256) @(posedge sys_clk);
    #1;
    `CHK({upper_counter, lower_counter}, 16'h0100, "carry into upper byte wrong")
    // Third full match since start: pulse high, wave high, both bytes cleared.
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK({lower_match_irq, lower_wave_pin, upper_counter, lower_counter}, 18'h30000, "cascade wave not toggled per match")
    `CHK(up_pulses, 0, "upper pulse in cascade")
    @(posedge sys_clk);
    lower_count_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK({lower_wave_pin, upper_counter, lower_counter}, 17'h0, "cascade stop wrong")
    // Cascade event counter on the lower external pin.
    cfg(1'b1, 3'h0, EX_SEL_EXT, 3'h0, 8'h01, 8'h00, 8'h00, 3'b010, 3'b000);
    measure(1, p);
    `CHK(p, 2056, "cascade event period wrong")
    final_report();
  end
endmodule : testbench

`default_nettype wire
